// [hw/occ_pkg.sv]
// package: register map, error codes and types of the override command checker
package occ_pkg;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [7:0] OCC_REG_CMD     = 8'h00;
    localparam logic [7:0] OCC_REG_SPEED   = 8'h04;
    localparam logic [7:0] OCC_REG_MAXSPD  = 8'h08;
    localparam logic [7:0] OCC_REG_CFG     = 8'h0c;
    localparam logic [7:0] OCC_REG_ERR     = 8'h10;
    localparam logic [7:0] OCC_REG_AXIS    = 8'h14;
    localparam logic [7:0] OCC_REG_IRQ_ST  = 8'h18;
    localparam logic [7:0] OCC_REG_IRQ_CLR = 8'h1c;
    localparam logic [7:0] OCC_REG_IRQ_EN  = 8'h20;

    // ****************************************
    // field layout and reset values
    // ****************************************
    localparam int          OCC_CMD_W       = 3;
    localparam int          OCC_ERR_W       = 10;
    localparam int          OCC_ERR_VLD_BIT = 16;
    localparam int          OCC_CFG_SCURVE  = 0;
    localparam int          OCC_IRQ_ACC     = 0;
    localparam int          OCC_IRQ_REJ     = 1;
    localparam int          OCC_IRQ_W       = 2;
    localparam int          OCC_AXIS_W      = 7;
    localparam logic [31:0] OCC_MAXSPD_RST  = 32'hffff_ffff;
    localparam logic [1:0]  OCC_RESP_OKAY   = 2'h0;
    localparam logic [1:0]  OCC_RESP_SLVERR = 2'h2;

    // ****************************************
    // error codes
    // ****************************************
    localparam logic [OCC_ERR_W-1:0] OCC_E_NONE = 10'h000;
    localparam logic [OCC_ERR_W-1:0] OCC_E365   = 10'd365;
    localparam logic [OCC_ERR_W-1:0] OCC_E366   = 10'd366;
    localparam logic [OCC_ERR_W-1:0] OCC_E371   = 10'd371;
    localparam logic [OCC_ERR_W-1:0] OCC_E372   = 10'd372;
    localparam logic [OCC_ERR_W-1:0] OCC_E373   = 10'd373;
    localparam logic [OCC_ERR_W-1:0] OCC_E374   = 10'd374;
    localparam logic [OCC_ERR_W-1:0] OCC_E375   = 10'd375;
    localparam logic [OCC_ERR_W-1:0] OCC_E377   = 10'd377;
    localparam logic [OCC_ERR_W-1:0] OCC_E378   = 10'd378;
    localparam logic [OCC_ERR_W-1:0] OCC_E381   = 10'd381;
    localparam logic [OCC_ERR_W-1:0] OCC_E382   = 10'd382;
    localparam logic [OCC_ERR_W-1:0] OCC_E383   = 10'd383;
    localparam logic [OCC_ERR_W-1:0] OCC_E384   = 10'd384;
    localparam logic [OCC_ERR_W-1:0] OCC_E385   = 10'd385;
    localparam logic [OCC_ERR_W-1:0] OCC_E386   = 10'd386;
    localparam logic [OCC_ERR_W-1:0] OCC_E389   = 10'd389;
    localparam logic [OCC_ERR_W-1:0] OCC_E390   = 10'd390;
    localparam logic [OCC_ERR_W-1:0] OCC_E391   = 10'd391;
    localparam logic [OCC_ERR_W-1:0] OCC_E392   = 10'd392;

    // ****************************************
    // types
    // ****************************************
    typedef enum logic [OCC_CMD_W-1:0] {
        OCC_CMD_NONE,
        OCC_CMD_POS_OVR,
        OCC_CMD_SPD_OVR,
        OCC_CMD_RND_OVR,
        OCC_CMD_CONT
    } occ_cmd_t;

    // axis state as seen by the checker; bit order is the AXIS register layout
    typedef struct packed {
        logic speed_ctrl;
        logic dwell;
        logic decel;
        logic sync_sub;
        logic circ;
        logic lin_sub;
        logic busy;
    } occ_axis_t;

endpackage

// [hw/occ_chk_if.sv]
// interface: command and axis state into the checker, verdict back out
`timescale 1ns/1ps
`default_nettype none
interface occ_chk_if;
    import occ_pkg::*;
    occ_cmd_t               cmd;
    logic [31:0]            speed;
    logic [31:0]            max_speed;
    logic                   scurve;
    occ_axis_t              axis;
    logic [OCC_ERR_W-1:0]   err_code;

    modport top (output cmd, speed, max_speed, scurve, axis, input err_code);
    modport chk (input cmd, speed, max_speed, scurve, axis, output err_code);
endinterface
`default_nettype wire

// [hw/occ_check.sv]
// checker: picks the error code of one command against the axis state
`timescale 1ns/1ps
`default_nettype none
module occ_check
    import occ_pkg::*;
(
    // verdict port
    occ_chk_if.chk c
);

    logic over;

    // lowest code wins when several reasons apply
    always_comb begin
        over       = c.speed > c.max_speed;
        c.err_code = OCC_E_NONE;
        unique case (c.cmd)
            OCC_CMD_POS_OVR: begin
                if (c.axis.circ) c.err_code = OCC_E365;
                else if (c.axis.sync_sub) c.err_code = OCC_E366;
            end
            OCC_CMD_SPD_OVR: begin
                if (!c.axis.busy) c.err_code = OCC_E371;
                else if (over) c.err_code = OCC_E372;
                else if (c.axis.lin_sub) c.err_code = OCC_E373;
                else if (c.axis.circ) c.err_code = OCC_E374;
                else if (c.axis.sync_sub) c.err_code = OCC_E375;
                else if (c.axis.decel) c.err_code = OCC_E377;
                else if (c.scurve) c.err_code = OCC_E378;
            end
            OCC_CMD_RND_OVR: begin
                if (!c.axis.busy) c.err_code = OCC_E381;
                else if (c.axis.speed_ctrl) c.err_code = OCC_E382;
                else if (over) c.err_code = OCC_E383;
                else if (c.axis.lin_sub) c.err_code = OCC_E384;
                else if (c.axis.circ) c.err_code = OCC_E385;
                else if (c.axis.sync_sub) c.err_code = OCC_E386;
                else if (c.scurve) c.err_code = OCC_E389;
            end
            OCC_CMD_CONT: begin
                if (c.scurve) c.err_code = OCC_E390;
                else if (!c.axis.busy) c.err_code = OCC_E391;
                else if (!c.axis.dwell) c.err_code = OCC_E392;
            end
            default: c.err_code = OCC_E_NONE;
        endcase
    end

endmodule
`default_nettype wire

// [hw/occ_top.sv]
// top: axi4-lite register file and command gate of the override command checker
//
// Notes on behaviour
// - position override on a circular-interpolation axis is refused with 365.
// - position override on a synchronous-start subordinate axis is refused with 366.
// - speed override on a stopped axis is refused with 371.
// - speed override above maximum speed is refused with 372; equal is fine.
// - speed override on a linear-interpolation subordinate is refused with 373.
// - speed override on a circular-interpolation axis is refused with 374.
// - speed override on a synchronous-start subordinate is refused with 375.
// - speed override during deceleration is refused with 377.
// - speed override with S-curve profile is refused with 378.
// - random-position speed override on a stopped axis is refused with 381.
// - random-position speed override under speed control is refused with 382.
// - random-position speed override above maximum speed is refused with 383.
// - random-position override: linear sub 384, circular 385, sync sub 386.
// - random-position speed override with S-curve profile is refused with 389.
// - continuous operation with S-curve profile is refused with 390.
// - continuous operation on a stopped axis is refused with 391.
// - continuous operation outside dwell is refused with 392.
//
// The register addresses and register access over AXI4-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module occ_top
    import occ_pkg::*;
(
    // clock and reset
    input  wire logic        aclk,
    input  wire logic        aresetn,
    // axi4-lite write address
    input  wire logic [7:0]  s_axi_awaddr,
    input  wire logic        s_axi_awvalid,
    output logic             s_axi_awready,
    // axi4-lite write data
    input  wire logic [31:0] s_axi_wdata,
    input  wire logic [3:0]  s_axi_wstrb,
    input  wire logic        s_axi_wvalid,
    output logic             s_axi_wready,
    // axi4-lite write response
    output logic [1:0]       s_axi_bresp,
    output logic             s_axi_bvalid,
    input  wire logic        s_axi_bready,
    // axi4-lite read address
    input  wire logic [7:0]  s_axi_araddr,
    input  wire logic        s_axi_arvalid,
    output logic             s_axi_arready,
    // axi4-lite read data
    output logic [31:0]      s_axi_rdata,
    output logic [1:0]       s_axi_rresp,
    output logic             s_axi_rvalid,
    input  wire logic        s_axi_rready,
    // axis state from the motion engine
    input  wire logic        axis_busy,
    input  wire logic        axis_decel,
    input  wire logic        axis_dwell,
    input  wire logic        axis_speed_ctrl,
    input  wire logic        axis_lin_sub,
    input  wire logic        axis_circ,
    input  wire logic        axis_sync_sub,
    // accepted command towards the motion engine
    output logic             cmd_valid,
    output logic [2:0]       cmd_type,
    output logic [31:0]      cmd_speed,
    // interrupt
    output logic             irq
);

    // ****************************************
    // state
    // ****************************************
    typedef struct packed {
        logic                 aw_have;
        logic [7:0]           aw_addr;
        logic                 w_have;
        logic [31:0]          w_data;
        logic [3:0]           w_strb;
        logic                 bvalid;
        logic [1:0]           bresp;
        logic                 rvalid;
        logic [31:0]          rdata;
        logic [1:0]           rresp;
        logic [31:0]          speed;
        logic [31:0]          max_speed;
        logic                 scurve;
        logic                 err_vld;
        logic [OCC_ERR_W-1:0] err_code;
        logic [OCC_IRQ_W-1:0] irq_st;
        logic [OCC_IRQ_W-1:0] irq_en;
        logic                 cmd_valid;
        logic [OCC_CMD_W-1:0] cmd_type;
        logic [31:0]          cmd_speed;
    } occ_state_t;

    localparam occ_state_t OCC_STATE_RST = '{
        max_speed: OCC_MAXSPD_RST,
        default:   '0
    };

    occ_state_t q;
    occ_state_t d;

    // ****************************************
    // checker
    // ****************************************
    occ_chk_if chk ();
    occ_axis_t  axis;
    occ_cmd_t   new_cmd;
    logic       do_write;
    logic       cmd_write;

    assign axis.busy       = axis_busy;
    assign axis.decel      = axis_decel;
    assign axis.dwell      = axis_dwell;
    assign axis.speed_ctrl = axis_speed_ctrl;
    assign axis.lin_sub    = axis_lin_sub;
    assign axis.circ       = axis_circ;
    assign axis.sync_sub   = axis_sync_sub;

    assign do_write  = q.aw_have && q.w_have && !q.bvalid;
    assign cmd_write = do_write && (q.aw_addr == OCC_REG_CMD) && q.w_strb[0];

    // codes beyond the last command are treated as no command
    always_comb begin
        if (q.w_data[OCC_CMD_W-1:0] > OCC_CMD_CONT) begin
            new_cmd = OCC_CMD_NONE;
        end else begin
            new_cmd = occ_cmd_t'(q.w_data[OCC_CMD_W-1:0]);
        end
    end

    assign chk.cmd       = cmd_write ? new_cmd : OCC_CMD_NONE;
    assign chk.speed     = q.speed;
    assign chk.max_speed = q.max_speed;
    assign chk.scurve    = q.scurve;
    assign chk.axis      = axis;

    occ_check u_check (
        .c (chk.chk)
    );

    // ****************************************
    // helpers
    // ****************************************
    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] val,
                                          input logic [3:0] strb);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (strb[i]) r[8*i +: 8] = val[8*i +: 8];
        end
        return r;
    endfunction

    // ****************************************
    // next state
    // ****************************************
    logic [OCC_IRQ_W-1:0] ev;
    logic                 hit;

    always_comb begin
        d           = q;
        ev          = '0;
        hit         = 1'b1;
        d.cmd_valid = 1'b0;

        // address and data are taken in either order and held until the write is done
        if (s_axi_awvalid && s_axi_awready) begin
            d.aw_have = 1'b1;
            d.aw_addr = s_axi_awaddr;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            d.w_have = 1'b1;
            d.w_data = s_axi_wdata;
            d.w_strb = s_axi_wstrb;
        end
        if (q.bvalid && s_axi_bready) begin
            d.bvalid = 1'b0;
        end

        if (do_write) begin
            d.aw_have = 1'b0;
            d.w_have  = 1'b0;
            d.bvalid  = 1'b1;
            unique case (q.aw_addr)
                OCC_REG_CMD: begin
                    // a refused command never reaches the motion engine
                    if (new_cmd != OCC_CMD_NONE && q.w_strb[0]) begin
                        if (chk.err_code == OCC_E_NONE) begin
                            d.cmd_valid = 1'b1;
                            d.cmd_type  = new_cmd;
                            d.cmd_speed = q.speed;
                            d.err_vld   = 1'b0;
                            d.err_code  = OCC_E_NONE;
                            ev[OCC_IRQ_ACC] = 1'b1;
                        end else begin
                            d.err_vld   = 1'b1;
                            d.err_code  = chk.err_code;
                            ev[OCC_IRQ_REJ] = 1'b1;
                        end
                    end
                end
                OCC_REG_SPEED:  d.speed     = merge(q.speed, q.w_data, q.w_strb);
                OCC_REG_MAXSPD: d.max_speed = merge(q.max_speed, q.w_data, q.w_strb);
                OCC_REG_CFG: begin
                    if (q.w_strb[0]) d.scurve = q.w_data[OCC_CFG_SCURVE];
                end
                OCC_REG_IRQ_CLR: begin
                    if (q.w_strb[0]) d.irq_st = q.irq_st & ~q.w_data[OCC_IRQ_W-1:0];
                end
                OCC_REG_IRQ_EN: begin
                    if (q.w_strb[0]) d.irq_en = q.w_data[OCC_IRQ_W-1:0];
                end
                OCC_REG_ERR, OCC_REG_AXIS, OCC_REG_IRQ_ST: hit = 1'b1;
                default: hit = 1'b0;
            endcase
            d.bresp = hit ? OCC_RESP_OKAY : OCC_RESP_SLVERR;
        end

        // set wins over a clear in the same cycle
        d.irq_st = d.irq_st | ev;

        if (q.rvalid && s_axi_rready) begin
            d.rvalid = 1'b0;
        end
        if (s_axi_arvalid && s_axi_arready) begin
            d.rvalid = 1'b1;
            d.rresp  = OCC_RESP_OKAY;
            d.rdata  = '0;
            unique case (s_axi_araddr)
                OCC_REG_SPEED:  d.rdata = q.speed;
                OCC_REG_MAXSPD: d.rdata = q.max_speed;
                OCC_REG_CFG:    d.rdata[OCC_CFG_SCURVE] = q.scurve;
                OCC_REG_ERR: begin
                    d.rdata[OCC_ERR_W-1:0]  = q.err_code;
                    d.rdata[OCC_ERR_VLD_BIT] = q.err_vld;
                end
                OCC_REG_AXIS:   d.rdata[OCC_AXIS_W-1:0] = axis;
                OCC_REG_IRQ_ST: d.rdata[OCC_IRQ_W-1:0]  = q.irq_st;
                OCC_REG_IRQ_EN: d.rdata[OCC_IRQ_W-1:0]  = q.irq_en;
                // command and clear registers are write-only and read as zero
                OCC_REG_CMD, OCC_REG_IRQ_CLR: d.rdata = '0;
                default: d.rresp = OCC_RESP_SLVERR;
            endcase
        end
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            q <= OCC_STATE_RST;
        end else begin
            q <= d;
        end
    end

    // ****************************************
    // outputs
    // ****************************************
    assign s_axi_awready = !q.aw_have;
    assign s_axi_wready  = !q.w_have;
    assign s_axi_bvalid  = q.bvalid;
    assign s_axi_bresp   = q.bresp;
    assign s_axi_arready = !q.rvalid;
    assign s_axi_rvalid  = q.rvalid;
    assign s_axi_rdata   = q.rdata;
    assign s_axi_rresp   = q.rresp;
    assign cmd_valid     = q.cmd_valid;
    assign cmd_type      = q.cmd_type;
    assign cmd_speed     = q.cmd_speed;
    assign irq           = |(q.irq_st & q.irq_en);

endmodule
`default_nettype wire

// [sim/occ_monitor.sv]
// checker: bus and command-gate properties at the ports of the override command checker
`timescale 1ns/1ps
`default_nettype none
module occ_monitor (
    // clock and reset
    input wire logic        aclk,
    input wire logic        aresetn,
    // register bus
    input wire logic        s_axi_awvalid,
    input wire logic        s_axi_awready,
    input wire logic        s_axi_wvalid,
    input wire logic        s_axi_wready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic        s_axi_arvalid,
    input wire logic        s_axi_arready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    // axis state and accepted command
    input wire logic        axis_busy,
    input wire logic        axis_decel,
    input wire logic        axis_dwell,
    input wire logic        axis_speed_ctrl,
    input wire logic        axis_lin_sub,
    input wire logic        axis_circ,
    input wire logic        axis_sync_sub,
    input wire logic        cmd_valid,
    input wire logic [2:0]  cmd_type
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    sequence s_wtake;
        s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready;
    endsequence
    sequence s_pulse;
        cmd_valid ##1 !cmd_valid;
    endsequence

    wr_resp_a: assert property (s_wtake |=> ##1 s_axi_bvalid)
        else $error("no write response after address and data");
    cmd_pulse_a: assert property (cmd_valid |-> $rose(s_axi_bvalid) and s_pulse)
        else $error("accepted command not a single pulse with the response");
    bresp_hold_a: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped before handshake");
    rdata_hold_a: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped before handshake");
    ar_block_a: assert property (s_axi_rvalid |-> !s_axi_arready)
        else $error("read address taken while data pending");
    rd_resp_a: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("no read data one cycle after address");
    pos_gate_a: assert property (cmd_valid && cmd_type == 3'h1 |->
        $past(!axis_circ && !axis_sync_sub))
        else $error("position override passed on a forbidden axis");
    spd_gate_a: assert property (cmd_valid && cmd_type == 3'h2 |->
        $past(axis_busy && !axis_lin_sub && !axis_circ && !axis_sync_sub && !axis_decel))
        else $error("speed override passed on a forbidden axis");
    rnd_gate_a: assert property (cmd_valid && cmd_type == 3'h3 |->
        $past(axis_busy && !axis_speed_ctrl && !axis_lin_sub && !axis_circ && !axis_sync_sub))
        else $error("random speed override passed on a forbidden axis");
    cont_gate_a: assert property (cmd_valid && cmd_type == 3'h4 |->
        $past(axis_busy && axis_dwell))
        else $error("continuous command passed on a forbidden axis");
endmodule
bind occ_top occ_monitor i_mon (.aclk, .aresetn, .s_axi_awvalid, .s_axi_awready, .s_axi_wvalid,
    .s_axi_wready, .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_arvalid, .s_axi_arready,
    .s_axi_rdata, .s_axi_rvalid, .s_axi_rready, .axis_busy, .axis_decel, .axis_dwell,
    .axis_speed_ctrl, .axis_lin_sub, .axis_circ, .axis_sync_sub, .cmd_valid, .cmd_type);
`default_nettype wire

// [sim/occ_seq_model.sv]
// partner: sequence program as an axi4-lite master issuing register accesses
`timescale 1ns/1ps
`default_nettype none
module occ_seq_model (
    // clock
    input  wire logic        aclk,
    // write channels
    output logic [7:0]       awaddr,
    output logic             awvalid,
    input  wire logic        awready,
    output logic [31:0]      wdata,
    output logic [3:0]       wstrb,
    output logic             wvalid,
    input  wire logic        wready,
    input  wire logic [1:0]  bresp,
    input  wire logic        bvalid,
    output logic             bready,
    // read channels
    output logic [7:0]       araddr,
    output logic             arvalid,
    input  wire logic        arready,
    input  wire logic [31:0] rdata,
    input  wire logic [1:0]  rresp,
    input  wire logic        rvalid,
    output logic             rready
);
    initial begin
        awaddr = 8'h00; awvalid = 1'b0; wdata = 32'h0; wstrb = 4'hf; wvalid = 1'b0;
        bready = 1'b0; araddr = 8'h00; arvalid = 1'b0; rready = 1'b0;
    end
    // leading edge keeps a new request out of the time step of the last release
    task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
        logic ad;
        logic wd;
        ad = 1'b0;
        wd = 1'b0;
        @(posedge aclk);
        awaddr <= a; wdata <= d; awvalid <= 1'b1; wvalid <= 1'b1; bready <= 1'b1;
        while (!(ad && wd)) begin
            @(posedge aclk);
            if (!ad && awready) begin ad = 1'b1; awvalid <= 1'b0; end
            if (!wd && wready) begin wd = 1'b1; wvalid <= 1'b0; end
        end
        do @(posedge aclk); while (bvalid !== 1'b1);
        r = bresp;
        bready <= 1'b0;
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
        @(posedge aclk);
        araddr <= a; arvalid <= 1'b1; rready <= 1'b1;
        do @(posedge aclk); while (arready !== 1'b1);
        arvalid <= 1'b0;
        do @(posedge aclk); while (rvalid !== 1'b1);
        d = rdata;
        r = rresp;
        rready <= 1'b0;
    endtask
endmodule
`default_nettype wire

// [sim/tb.sv]
// testbench: command screening, error latch, interrupts and registers of the checker
`timescale 1ns/1ps
`default_nettype none
module tb;
    import occ_pkg::*;
    logic        aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic        arvalid, arready, rvalid, rready, cmd_valid, irq;
    logic [7:0]  awaddr, araddr;
    logic [31:0] wdata, rdata, cmd_speed, last_s;
    logic [3:0]  wstrb;
    logic [1:0]  bresp, rresp;
    logic [2:0]  cmd_type, last_t;
    logic [6:0]  axis_v;
    int          n_errors, tests_run;
    int          n_acc = 0;

    initial begin aclk = 1'b0; forever #2.5 aclk = ~aclk; end
    always @(posedge aclk) if (cmd_valid === 1'b1) n_acc <= n_acc + 1;

    occ_top i_dut (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
        .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
        .axis_busy(axis_v[0]), .axis_lin_sub(axis_v[1]), .axis_circ(axis_v[2]),
        .axis_sync_sub(axis_v[3]), .axis_decel(axis_v[4]), .axis_dwell(axis_v[5]),
        .axis_speed_ctrl(axis_v[6]), .cmd_valid(cmd_valid), .cmd_type(cmd_type),
        .cmd_speed(cmd_speed), .irq(irq));
    occ_seq_model i_seq (.aclk(aclk), .awaddr(awaddr), .awvalid(awvalid), .awready(awready),
        .wdata(wdata), .wstrb(wstrb), .wvalid(wvalid), .wready(wready), .bresp(bresp),
        .bvalid(bvalid), .bready(bready), .araddr(araddr), .arvalid(arvalid),
        .arready(arready), .rdata(rdata), .rresp(rresp), .rvalid(rvalid), .rready(rready));

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t mismatch got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic w(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
        logic [1:0] r;
        i_seq.wr(a, d, r);
        chk({30'h0, r}, {30'h0, er});
    endtask
    task automatic rdx(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] d;
        logic [1:0]  r;
        i_seq.rd(a, d, r);
        chk(d, e);
        chk({30'h0, r}, {30'h0, (a > OCC_REG_IRQ_EN) ? OCC_RESP_SLVERR : OCC_RESP_OKAY});
    endtask
    // one command against a given axis state; code 0 means it must be accepted
    task automatic issue(input logic [6:0] ax, input logic sc, input logic [31:0] sp,
                         input logic [2:0] c, input logic [9:0] code);
        int n0;
        axis_v <= ax;
        w(OCC_REG_CFG, {31'h0, sc}, OCC_RESP_OKAY);
        w(OCC_REG_SPEED, sp, OCC_RESP_OKAY);
        n0 = n_acc;
        w(OCC_REG_CMD, {29'h0, c}, OCC_RESP_OKAY);
        rdx(OCC_REG_AXIS, {25'h0, ax});
        rdx(OCC_REG_ERR, (code == 10'h0) ? 32'h0 : (32'h1_0000 | {22'h0, code}));
        chk(32'(n_acc - n0), (code == 10'h0) ? 32'h1 : 32'h0);
        if (code == 10'h0) begin last_t = c; last_s = sp; end
        chk({29'h0, cmd_type}, {29'h0, last_t});
        chk(cmd_speed, last_s);
    endtask

    task automatic t_regs;
        rdx(OCC_REG_MAXSPD, OCC_MAXSPD_RST);
        rdx(OCC_REG_ERR, 32'h0);
        chk({31'h0, irq}, 32'h0);
        w(8'h40, 32'h1, OCC_RESP_SLVERR);
        rdx(8'h40, 32'h0);
        w(OCC_REG_MAXSPD, 32'h3e8, OCC_RESP_OKAY);
        rdx(OCC_REG_MAXSPD, 32'h3e8);
        rdx(OCC_REG_CMD, 32'h0);
    endtask
    task automatic t_pos;
        issue(7'h05, 1'b0, 32'h10, 3'h1, OCC_E365);
        issue(7'h09, 1'b0, 32'h10, 3'h1, OCC_E366);
        issue(7'h01, 1'b0, 32'h11, 3'h1, OCC_E_NONE);
    endtask
    task automatic t_spd;
        issue(7'h00, 1'b0, 32'h3e9, 3'h2, OCC_E371);
        issue(7'h01, 1'b0, 32'h3e9, 3'h2, OCC_E372);
        issue(7'h03, 1'b0, 32'h20, 3'h2, OCC_E373);
        issue(7'h05, 1'b0, 32'h20, 3'h2, OCC_E374);
        issue(7'h09, 1'b0, 32'h20, 3'h2, OCC_E375);
        issue(7'h11, 1'b0, 32'h20, 3'h2, OCC_E377);
        issue(7'h01, 1'b1, 32'h20, 3'h2, OCC_E378);
        issue(7'h01, 1'b0, 32'h3e8, 3'h2, OCC_E_NONE);
    endtask
    task automatic t_rnd;
        issue(7'h00, 1'b0, 32'h30, 3'h3, OCC_E381);
        issue(7'h41, 1'b0, 32'h30, 3'h3, OCC_E382);
        issue(7'h01, 1'b0, 32'h3e9, 3'h3, OCC_E383);
        issue(7'h03, 1'b0, 32'h30, 3'h3, OCC_E384);
        issue(7'h05, 1'b0, 32'h30, 3'h3, OCC_E385);
        issue(7'h09, 1'b0, 32'h30, 3'h3, OCC_E386);
        issue(7'h01, 1'b1, 32'h30, 3'h3, OCC_E389);
        issue(7'h01, 1'b0, 32'h3e8, 3'h3, OCC_E_NONE);
    endtask
    task automatic t_cont;
        issue(7'h21, 1'b1, 32'h40, 3'h4, OCC_E390);
        issue(7'h20, 1'b0, 32'h40, 3'h4, OCC_E391);
        issue(7'h01, 1'b0, 32'h40, 3'h4, OCC_E392);
        issue(7'h21, 1'b0, 32'h41, 3'h4, OCC_E_NONE);
    endtask
    task automatic t_hold;
        issue(7'h00, 1'b0, 32'h50, 3'h2, OCC_E371);
        w(OCC_REG_CMD, 32'h0, OCC_RESP_OKAY);
        rdx(OCC_REG_ERR, 32'h1_0000 | {22'h0, OCC_E371});
    endtask
    task automatic t_irq;
        w(OCC_REG_IRQ_CLR, 32'h3, OCC_RESP_OKAY);
        rdx(OCC_REG_IRQ_ST, 32'h0);
        issue(7'h00, 1'b0, 32'h50, 3'h4, OCC_E391);
        rdx(OCC_REG_IRQ_ST, 32'h2);
        chk({31'h0, irq}, 32'h0);
        w(OCC_REG_IRQ_EN, 32'h2, OCC_RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
        w(OCC_REG_IRQ_CLR, 32'h2, OCC_RESP_OKAY);
        rdx(OCC_REG_IRQ_ST, 32'h0);
        chk({31'h0, irq}, 32'h0);
        issue(7'h21, 1'b0, 32'h51, 3'h4, OCC_E_NONE);
        rdx(OCC_REG_IRQ_ST, 32'h1);
        w(OCC_REG_IRQ_EN, 32'h1, OCC_RESP_OKAY);
        chk({31'h0, irq}, 32'h1);
    endtask

    task automatic final_report;
        $display("checks %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        aresetn = 1'b0; axis_v = 7'h0; n_errors = 0; tests_run = 0;
        last_t = 3'h0; last_s = 32'h0;
        repeat (5) @(posedge aclk);
        aresetn <= 1'b1;
        t_regs; t_pos; t_spd; t_rnd; t_cont; t_hold; t_irq;
        final_report;
    end
    // about 500 cycles of traffic; forty times that means a hang
    initial begin
        #100000;
        n_errors++;
        final_report;
    end
endmodule
`default_nettype wire
